// ==== pkg/tawg_pkg.sv ====
// tawg_pkg: constants for the timed access write guard.
// assumes an 8-bit special function register bus with single-cycle writes.
package tawg_pkg;
  // ******************************************************************
  // register map
  // ******************************************************************
  localparam logic [7:0] UNLOCK_KEY_ADDR = 8'hC7;
  localparam logic [7:0] CHIP_CONTROL_ADDR = 8'h9F;
  localparam logic [7:0] PROGRAM_TRIGGER_ADDR = 8'hA4;
  localparam logic [7:0] POWER_MONITOR_CONTROL_ADDR = 8'hAC;
  localparam logic [7:0] WATCHDOG_CONTROL_ADDR = 8'hAA;
  localparam logic [7:0] UNLOCK_KEY_RESET = 8'h00;
  localparam logic [7:0] PROT_RESET = 8'h00;
  // ******************************************************************
  // key values and timing
  // ******************************************************************
  localparam logic [7:0] KEY_FIRST = 8'hAA;
  localparam logic [7:0] KEY_SECOND = 8'h55;
  localparam int KEY_WAIT_MC = 3;
  localparam int WINDOW_MC = 3;
  localparam int MC_CLOCKS = 1;
  localparam int KEY_WAIT_CLOCKS = KEY_WAIT_MC * MC_CLOCKS;
  localparam int WINDOW_CLOCKS = WINDOW_MC * MC_CLOCKS;
  localparam int CNT_W = 4;
endpackage

// ==== core/tawg_countdown.sv ====
// tawg_countdown: loadable down-counter with an active flag.
// assumes load and the counted clock share the guard's clock.
`timescale 1ns/10ps
module tawg_countdown #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic load,
  input wire logic clear,
  input wire logic [W-1:0] load_value,
  output logic active,
  output logic last
);
  logic [W-1:0] count;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
    end else if (load) begin
      count <= load_value;
    end else if (clear) begin
      count <= '0;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign active = (count != '0);
  // final counted cycle: lets a registered copy of active drop on time
  assign last = (count == W'(1));
endmodule // tawg_countdown

// ==== core/tawg_guard.sv ====
// tawg_guard: timed access guard for the protected control registers.
// assumes one core write per clock, address/data valid while wr_en is high.
// a machine cycle is MC_CLOCKS clocks of clk.
//
// Overview of operation
// - unlock needs first key then second key written to key register, in order.
// - first key starts a wait; second key must arrive within three machine cycles.
// - window stays open exactly three machine cycles for protected writes.
// - protected writes outside the window are dropped, register unchanged.
// - window closes itself; a fresh unlock is needed afterwards.
// - protected registers and key register read freely at all times.
// - protected set is chip control, program trigger, power monitor, watchdog.
// - a protected write landing after the window leaves the register unchanged.
`timescale 1ns/10ps
module tawg_guard (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic [7:0] unlock_key_register,
  output logic [7:0] chip_control_reg,
  output logic [7:0] program_trigger_reg,
  output logic [7:0] power_monitor_control_reg,
  output logic [7:0] watchdog_control_reg,
  output logic window_open
);
  localparam int W = tawg_pkg::CNT_W;

  // elaboration check: both counts must fit the shared counter width
  if (tawg_pkg::KEY_WAIT_CLOCKS >= (1 << W) || tawg_pkg::WINDOW_CLOCKS >= (1 << W)) begin : g_chk
    $error("tawg_guard: counter width too small");
  end

  // ******************************************************************
  // decode
  // ******************************************************************
  logic key_wr;
  logic first_key;
  logic second_key;
  logic wait_active;
  logic win_active;
  logic win_last;
  logic prot_ok;
  logic hit_chip;
  logic hit_trig;
  logic hit_power;
  logic hit_watchdog;

  assign key_wr = wr_en && (addr == tawg_pkg::UNLOCK_KEY_ADDR);
  assign first_key = key_wr && (wdata == tawg_pkg::KEY_FIRST);
  // second key only counts while the wait is running; late ones are ignored
  assign second_key = key_wr && (wdata == tawg_pkg::KEY_SECOND) && wait_active;
  assign prot_ok = wr_en && win_active;
  // only these four addresses are gated; every other write passes untouched
  assign hit_chip = prot_ok && (addr == tawg_pkg::CHIP_CONTROL_ADDR);
  assign hit_trig = prot_ok && (addr == tawg_pkg::PROGRAM_TRIGGER_ADDR);
  assign hit_power = prot_ok && (addr == tawg_pkg::POWER_MONITOR_CONTROL_ADDR);
  assign hit_watchdog = prot_ok && (addr == tawg_pkg::WATCHDOG_CONTROL_ADDR);

  // ******************************************************************
  // timers
  // ******************************************************************
  // wait for second key; any other key write abandons it
  tawg_countdown #(.W(W)) u_wait (
    .clk(clk),
    .rstn(rstn),
    .load(first_key),
    .clear(key_wr && !first_key),
    .load_value(W'(tawg_pkg::KEY_WAIT_CLOCKS)),
    .active(wait_active),
    .last()
  );

  // open window, closes by itself when the count runs out
  tawg_countdown #(.W(W)) u_window (
    .clk(clk),
    .rstn(rstn),
    .load(second_key),
    .clear(1'b0),
    .load_value(W'(tawg_pkg::WINDOW_CLOCKS)),
    .active(win_active),
    .last(win_last)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      window_open <= 1'b0;
    end else begin
      // registered twin of win_active: drops with the last counted cycle, not one later
      window_open <= second_key || (win_active && !win_last);
    end
  end

  // ******************************************************************
  // registers
  // ******************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      unlock_key_register <= tawg_pkg::UNLOCK_KEY_RESET;
    end else if (key_wr) begin
      unlock_key_register <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chip_control_reg <= tawg_pkg::PROT_RESET;
    end else if (hit_chip) begin
      chip_control_reg <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      program_trigger_reg <= tawg_pkg::PROT_RESET;
    end else if (hit_trig) begin
      program_trigger_reg <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      power_monitor_control_reg <= tawg_pkg::PROT_RESET;
    end else if (hit_power) begin
      power_monitor_control_reg <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      watchdog_control_reg <= tawg_pkg::PROT_RESET;
    end else if (hit_watchdog) begin
      watchdog_control_reg <= wdata;
    end
  end

  // reads ignore the window entirely
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      unique case (addr)
        tawg_pkg::UNLOCK_KEY_ADDR: rdata <= unlock_key_register;
        tawg_pkg::CHIP_CONTROL_ADDR: rdata <= chip_control_reg;
        tawg_pkg::PROGRAM_TRIGGER_ADDR: rdata <= program_trigger_reg;
        tawg_pkg::POWER_MONITOR_CONTROL_ADDR: rdata <= power_monitor_control_reg;
        tawg_pkg::WATCHDOG_CONTROL_ADDR: rdata <= watchdog_control_reg;
        default: rdata <= 8'h00;
      endcase
    end
  end
endmodule // tawg_guard

// ==== bench/tawg_checker.sv ====
// tawg_checker: guard port timing; assumes one clock per machine cycle.
`timescale 1ns/10ps
module tawg_checker (
  input logic clk,
  input logic rstn,
  input logic wr_en,
  input logic rd_en,
  input logic [7:0] addr,
  input logic [7:0] wdata,
  input logic [7:0] rdata,
  input logic [7:0] chip_control_reg,
  input logic window_open);
  wire ka = wr_en && addr == 8'hC7 && wdata == 8'hAA;
  wire kb = wr_en && addr == 8'hC7 && wdata == 8'h55;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_op; $rose(window_open) |-> $past(kb); endproperty
  a_op: assert property (p_op) else $error("open");
  property p_wt; $rose(window_open) |-> $past(ka, 2) || $past(ka, 3) || $past(ka, 4); endproperty
  a_wt: assert property (p_wt) else $error("wait");
  property p_len; $rose(window_open) |-> window_open[*3]; endproperty
  a_len: assert property (p_len) else $error("len");
  property p_end; $fell(window_open) |-> $past(kb, 4); endproperty
  a_end: assert property (p_end) else $error("end");
  property p_cls; (!kb)[*3] |=> !window_open; endproperty
  a_cls: assert property (p_cls) else $error("cls");
  property p_drp; !window_open |=> $stable(chip_control_reg); endproperty
  a_drp: assert property (p_drp) else $error("drop");
  property p_acc; wr_en && addr == 8'h9F && window_open |=> chip_control_reg == $past(wdata);
  endproperty
  a_acc: assert property (p_acc) else $error("acc");
  property p_rd; rd_en && addr == 8'h9F |=> rdata == $past(chip_control_reg); endproperty
  a_rd: assert property (p_rd) else $error("read");
  c_o: cover property ($rose(window_open));
  c_l: cover property (ka ##4 kb);
  c_f: cover property ($fell(window_open));
endmodule // tawg_checker
bind tawg_guard tawg_checker chk_u (.*);

// ==== bench/tawg_guard_tb.sv ====
// tawg_guard_tb: key gap and write delay sweep; assumes reads answer a clock later.
`timescale 1ns/10ps
module tawg_guard_tb;
  logic clk = 0, rstn = 0, wr_en = 0, rd_en = 0, rv = 0, window_open;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, e, q [$], m [4] = '{default: 8'h00};
  logic [7:0] unlock_key_register, chip_control_reg, program_trigger_reg, watchdog_control_reg;
  logic [7:0] power_monitor_control_reg, pa [4] = '{8'h9F, 8'hA4, 8'hAC, 8'hAA};
  logic [31:0] s = 32'h6641;
  int errors = 0, tests_run = 0, t;
  always #2.5 clk = ~clk;
  tawg_guard dut_u (.*);
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task op(input logic w, r, input logic [7:0] a, d);
    @(posedge clk);
    #1 {wr_en, rd_en, addr, wdata} = {w, r, a, d};
    if (r) q.push_back(d);
  endtask
  task report_and_stop;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rv) e = q.pop_front();
    tests_run += rv;
    if (rv && rdata !== e) begin
      errors++;
      $display("FAIL rdata exp %h got %h", e, rdata);
    end
    rv = rd_en;
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 rstn = 1;
    for (int i = 0; i < 16; i++) begin
      s = xs(s);
      t = (i + i / 4) % 4;
      op(1, 0, 8'hC7, 8'hAA);
      repeat (i / 4) op(0, 0, 8'h00, 8'h00);
      op(1, 0, 8'hC7, 8'h55);
      repeat (i % 4) op(0, 0, 8'h00, 8'h00);
      op(1, 0, pa[t], s[7:0]);
      if (i < 12 && i % 4 < 3) m[t] = s[7:0];
      op(0, 1, pa[t], m[t]);
      op(0, 1, 8'hC7, 8'h55);
    end
    repeat (2) op(0, 0, 8'h00, 8'h00);
    report_and_stop;
  end
  initial begin
    #5000 errors++;
    report_and_stop;
  end
endmodule // tawg_guard_tb
